//--- rtl/fcs_sequencer.sv
// Flash command sequencer: read/automatic mode control and command decode
// Functional notes
// R1 - Read mode at power-up, reset, normal end
// R2 - Two modes; automatic only via valid sequence
// R3 - Automatic mode: no reads, only its end or reset exits
// R4 - Abnormal end stays out of read mode
// R5 - Single word store 0xF0 returns read mode
// R6 - Read/reset completes on third write cycle
// R7 - Read/reset aborts partial or wrong sequence
// R8 - Start operation only on matching sequence
// R9 - Deviating write cycle abandons the command
// R10 - Host drives region bits [31:21] correctly
// R11 - Host uses only 32-bit word stores
// R12 - Write cycles at least 15 clocks apart
// R13 - Host runs command code outside flash
// R14 - Host makes no flash reads between cycles
// R15 - Host issues barrier after each store
// R16 - Host checks ready flag before commands
// R17 - Host recovers from mistakes by reset
// R18 - Accepted command runs without host control
// R19 - Chip erase and 128 kB block erase
// R20 - Per-block protection; all protected flagged
// R21 - Hardware reset ends operation, read mode
// R22 - Ready flag shows operation, 1 in read
// R23 - Sequence position cleared on read entry
`timescale 1ns/1ps
module fcs_sequencer
    import fcs_pkg::*;
#(
    parameter int NBLK = 4,
    parameter logic [10:0] REGION_BASE = 11'h000
)
(
    // Clock, reset, enable
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic clk_en,
    // Processor store and read strobes
    input wire logic wr_valid,
    input wire logic [31:0] wr_addr,
    input wire logic [31:0] wr_data,
    input wire logic wr_word,
    input wire logic rd_flash,
    // Array engine results and protection
    input wire logic array_done,
    input wire logic array_fail,
    input wire logic [NBLK-1:0] block_protect,
    // Status
    output logic ready_busy_flag,
    output logic mode_fail,
    output logic [2:0] seq_pos,
    output logic cmd_abort,
    output logic all_protected,
    // Array engine control
    output logic op_start,
    output logic [1:0] op_kind,
    output logic [31:0] op_addr,
    output logic prog_wr,
    output logic [31:0] prog_data
);

    // ========================================================
    // Parameter checks
    localparam int BLK_W = (NBLK > 1) ? $clog2(NBLK) : 1;

    if (NBLK < 2 || NBLK > 16 || (1 << BLK_W) != NBLK)
    begin : g_bad_nblk
        $error("NBLK must be a power of two from 2 to 16");
    end

    // ========================================================
    // State
    fcs_mode_t mode;
    fcs_mode_t next_mode;
    logic erase_path;
    logic next_erase;
    logic [2:0] next_pos;
    logic [3:0] gap_cnt;
    logic go;
    logic [1:0] go_kind;
    logic abort;

    // ========================================================
    // Decode of the current bus write cycle
    logic region_ok;
    logic gap_ok;
    logic wr_acc;
    logic on_ka;
    logic on_kb;
    logic first_ok;
    logic page_top;
    logic [BLK_W-1:0] blk;

    // Region bits must match; half and byte stores never count
    assign region_ok = wr_addr[REGION_LSB +: REGION_W] == REGION_BASE;
    assign gap_ok = gap_cnt >= 4'(SPACING_CYC); // [R12]
    assign wr_acc = region_ok && wr_word && (seq_pos == POS_IDLE || gap_ok);
    assign on_ka = wr_addr[KEY_LSB +: KEY_W] == KEY_A;
    assign on_kb = wr_addr[KEY_LSB +: KEY_W] == KEY_B;
    assign first_ok = wr_acc && on_ka && wr_data == DATA_UNLOCK_A;
    assign page_top = wr_addr[PAGE_W-1:0] == '0;
    assign blk = wr_addr[BLK_LSB +: BLK_W]; // 128 kB blocks [R19]

    // ========================================================
    // Command recognition and mode transitions
    always_comb
    begin
        next_mode = mode;
        next_pos = seq_pos;
        next_erase = erase_path;
        go = 1'b0;
        go_kind = OP_PROG;
        abort = 1'b0;
        if (mode == MD_AUTO)
        begin
            // Stores and interrupts cannot leave this mode [R3]
            if (array_fail)
                next_mode = MD_FAIL; // [R4]
            else if (array_done)
                next_mode = MD_READ; // [R1]
        end
        else if (wr_valid)
        begin
            if (!wr_acc)
                abort = 1'b1; // [R9]
            else if (wr_data == CMD_READ)
            begin
                // Single Read, or third cycle of Read/reset [R5] [R6] [R7]
                next_mode = MD_READ;
                next_pos = POS_IDLE;
                next_erase = 1'b0;
            end
            else
            begin
                unique case (seq_pos)
                    POS_IDLE:
                        if (first_ok)
                            next_pos = POS_1;
                        else
                            abort = 1'b1;
                    POS_1:
                        if (on_kb && wr_data == DATA_UNLOCK_B)
                            next_pos = POS_2;
                        else
                            abort = 1'b1;
                    POS_2:
                        // A failed array accepts only the reset command
                        if (!on_ka || mode == MD_FAIL)
                            abort = 1'b1;
                        else if (wr_data == CMD_PROG)
                            next_pos = POS_3;
                        else if (wr_data == CMD_ERASE)
                        begin
                            next_pos = POS_3;
                            next_erase = 1'b1;
                        end
                        else
                            abort = 1'b1;
                    POS_3:
                        if (erase_path)
                        begin
                            if (first_ok)
                                next_pos = POS_4;
                            else
                                abort = 1'b1;
                        end
                        else if (!page_top)
                            abort = 1'b1;
                        else if (block_protect[blk])
                            next_pos = POS_IDLE; // [R20]
                        else
                        begin
                            go = 1'b1; // [R8]
                            go_kind = OP_PROG;
                        end
                    POS_4:
                        if (on_kb && wr_data == DATA_UNLOCK_B)
                            next_pos = POS_5;
                        else
                            abort = 1'b1;
                    POS_5:
                        if (on_ka && wr_data == CMD_CHIP)
                        begin
                            next_pos = POS_IDLE;
                            next_erase = 1'b0;
                            if (!(&block_protect))
                            begin
                                go = 1'b1; // [R19]
                                go_kind = OP_CHIP;
                            end
                        end
                        else if (wr_data == CMD_BLOCK)
                        begin
                            next_pos = POS_IDLE;
                            next_erase = 1'b0;
                            if (!block_protect[blk])
                            begin
                                go = 1'b1; // [R19] [R20]
                                go_kind = OP_BLOCK;
                            end
                        end
                        else
                            abort = 1'b1;
                    default:
                        abort = 1'b1;
                endcase
            end
            if (go)
            begin
                next_mode = MD_AUTO; // [R2] [R18]
                next_pos = POS_IDLE;
                next_erase = 1'b0;
            end
        end
        else if (rd_flash && seq_pos != POS_IDLE)
            abort = 1'b1; // A stray read breaks recognition [R14]
        if (abort)
        begin
            // A fresh first cycle restarts at once, so reset still lands
            next_pos = first_ok ? POS_1 : POS_IDLE; // [R7] [R9]
            next_erase = 1'b0;
        end
    end

    // ========================================================
    // Mode and sequence position; hardware reset wins over all
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            mode <= MD_READ; // [R1] [R21]
            seq_pos <= POS_IDLE;
            erase_path <= 1'b0;
        end
        else if (clk_en)
        begin
            mode <= next_mode;
            seq_pos <= next_pos; // [R23]
            erase_path <= next_erase;
        end
    end

    // ========================================================
    // Spacing counter, saturating, restarted by every store
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            gap_cnt <= GAP_MAX;
        else if (clk_en)
        begin
            if (wr_valid)
                gap_cnt <= GAP_ONE; // [R12]
            else if (gap_cnt != GAP_MAX)
                gap_cnt <= gap_cnt + GAP_ONE;
        end
    end

    // ========================================================
    // Status outputs
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            ready_busy_flag <= RDY_RESET;
            mode_fail <= 1'b0;
            cmd_abort <= 1'b0;
            all_protected <= 1'b0;
        end
        else if (clk_en)
        begin
            ready_busy_flag <= next_mode == MD_READ; // [R22]
            mode_fail <= next_mode == MD_FAIL;
            cmd_abort <= abort;
            all_protected <= &block_protect; // [R20]
        end
    end

    // ========================================================
    // Array engine control; page data is forwarded while programming
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            op_start <= 1'b0;
            op_kind <= OP_PROG;
            op_addr <= ADDR_RESET;
            prog_wr <= 1'b0;
            prog_data <= ADDR_RESET;
        end
        else if (clk_en)
        begin
            op_start <= go;
            if (go)
            begin
                op_kind <= go_kind;
                op_addr <= wr_addr; // Page top, block, or chip erase command address
            end
            prog_wr <= mode == MD_AUTO && op_kind == OP_PROG && wr_valid
                && wr_word && region_ok; // [R18]
            if (mode == MD_AUTO && wr_valid)
                prog_data <= wr_data;
        end
    end

    // ========================================================
    // Checks
    sequence s_reset_third;
        clk_en && wr_valid && wr_acc && seq_pos == POS_2 && on_ka
            && wr_data == CMD_READ && mode != MD_AUTO;
    endsequence

    sequence s_block_prot;
        clk_en && wr_valid && wr_acc && seq_pos == POS_5 && mode != MD_AUTO
            && wr_data == CMD_BLOCK && block_protect[blk];
    endsequence

    chk_normal_end: assert property (@(posedge clk_sys) disable iff (!resetn) // [R1]
        clk_en && mode == MD_AUTO && array_done && !array_fail
        |=> mode == MD_READ && ready_busy_flag)
        else $error("normal end did not return to read mode");

    chk_auto_entry: assert property (@(posedge clk_sys) disable iff (!resetn) // [R8]
        clk_en && go |=> mode == MD_AUTO && op_start && !ready_busy_flag)
        else $error("accepted command did not start operation");

    chk_no_stray_auto: assert property (@(posedge clk_sys) disable iff (!resetn) // [R2]
        clk_en && mode != MD_AUTO && !go |=> mode != MD_AUTO)
        else $error("automatic mode entered without a command");

    chk_auto_holds: assert property (@(posedge clk_sys) disable iff (!resetn) // [R3]
        mode == MD_AUTO && !array_done && !array_fail
        |=> mode == MD_AUTO && !ready_busy_flag)
        else $error("automatic mode left without an end");

    chk_fail_stays: assert property (@(posedge clk_sys) disable iff (!resetn) // [R4]
        mode == MD_FAIL && !(clk_en && wr_valid)
        |=> mode == MD_FAIL && !ready_busy_flag && mode_fail)
        else $error("failed mode left without a command");

    chk_read_cmd: assert property (@(posedge clk_sys) disable iff (!resetn) // [R5]
        clk_en && wr_valid && wr_acc && wr_data == CMD_READ
            && mode != MD_AUTO
        |=> mode == MD_READ && seq_pos == POS_IDLE && ready_busy_flag)
        else $error("read command did not restore read mode");

    chk_reset_third: assert property (@(posedge clk_sys) disable iff (!resetn) // [R6]
        s_reset_third |=> mode == MD_READ && seq_pos == POS_IDLE)
        else $error("read/reset did not complete");

    chk_bad_store: assert property (@(posedge clk_sys) disable iff (!resetn) // [R9]
        clk_en && wr_valid && !wr_word && mode != MD_AUTO
        |=> seq_pos == POS_IDLE && cmd_abort)
        else $error("non-word store did not abandon command");

    chk_gap_short: assert property (@(posedge clk_sys) disable iff (!resetn) // [R12]
        clk_en && wr_valid && seq_pos != POS_IDLE && !gap_ok
            && mode != MD_AUTO
        |=> seq_pos == POS_IDLE)
        else $error("closely spaced write cycle was accepted");

    chk_prot_block: assert property (@(posedge clk_sys) disable iff (!resetn) // [R20]
        s_block_prot |=> mode == MD_READ && !op_start)
        else $error("protected block erase was started");

    chk_rdy_mode: assert property (@(posedge clk_sys) disable iff (!resetn) // [R22]
        ##1 ready_busy_flag == (mode == MD_READ))
        else $error("ready flag disagrees with mode");

    chk_read_entry: assert property (@(posedge clk_sys) disable iff (!resetn) // [R23]
        $rose(ready_busy_flag) |-> seq_pos == POS_IDLE && !erase_path)
        else $error("sequence position kept on read entry");

    chk_prog_fwd: assert property (@(posedge clk_sys) disable iff (!resetn) // [R18]
        clk_en && mode == MD_AUTO && op_kind == OP_PROG && wr_valid
            && wr_word && region_ok
        |=> prog_wr && prog_data == $past(wr_data))
        else $error("program data not forwarded");

endmodule

//--- rtl/fcs_pkg.sv
// Constants and types shared by the flash command sequencer
package fcs_pkg;

    // ========================================================
    // Operating modes and automatic operation kinds
    typedef enum logic [1:0] {MD_READ, MD_AUTO, MD_FAIL} fcs_mode_t;

    localparam logic [1:0] OP_PROG = 2'h0;
    localparam logic [1:0] OP_CHIP = 2'h1;
    localparam logic [1:0] OP_BLOCK = 2'h2;

    // ========================================================
    // Address fields of a command bus write cycle
    localparam int REGION_LSB = 21;
    localparam int REGION_W = 11;
    localparam int KEY_LSB = 8;
    localparam int KEY_W = 13;
    localparam int BLK_LSB = 17;
    localparam int PAGE_W = 9;

    // Command address keys, address bits [20:8]
    localparam logic [12:0] KEY_A = 13'h0555;
    localparam logic [12:0] KEY_B = 13'h02aa;

    // ========================================================
    // Command data words
    localparam logic [31:0] DATA_UNLOCK_A = 32'h0000_00aa;
    localparam logic [31:0] DATA_UNLOCK_B = 32'h0000_0055;
    localparam logic [31:0] CMD_READ = 32'h0000_00f0;
    localparam logic [31:0] CMD_PROG = 32'h0000_00a0;
    localparam logic [31:0] CMD_ERASE = 32'h0000_0080;
    localparam logic [31:0] CMD_CHIP = 32'h0000_0010;
    localparam logic [31:0] CMD_BLOCK = 32'h0000_0030;

    // ========================================================
    // Positions within a command sequence
    localparam logic [2:0] POS_IDLE = 3'h0;
    localparam logic [2:0] POS_1 = 3'h1;
    localparam logic [2:0] POS_2 = 3'h2;
    localparam logic [2:0] POS_3 = 3'h3;
    localparam logic [2:0] POS_4 = 3'h4;
    localparam logic [2:0] POS_5 = 3'h5;

    // ========================================================
    // Timing: least spacing of bus write cycles, in system clocks
    localparam int SPACING_CYC = 15;
    localparam logic [3:0] GAP_MAX = 4'hf;
    localparam logic [3:0] GAP_ONE = 4'h1;

    // ========================================================
    // Reset values
    localparam logic RDY_RESET = 1'b1;
    localparam logic [31:0] ADDR_RESET = 32'h0000_0000;

endpackage

//--- verif/fcs_host_model.sv
// Processor-side model that issues word and non-word store bus cycles and stray reads to the sequencer
`timescale 1ns/1ps
module fcs_host_model
    import fcs_pkg::*;
(
    // Clock
    input wire logic clk_sys,
    // Store and read strobes
    output logic wr_valid,
    output logic [31:0] wr_addr,
    output logic [31:0] wr_data,
    output logic wr_word,
    output logic rd_flash
);
    // ========================================================
    // Idle levels; command code runs outside the flash
    initial
    begin
        wr_valid = 1'b0;
        wr_addr = 32'h0000_0000;
        wr_data = 32'h0000_0000;
        wr_word = 1'b1;
        rd_flash = 1'b0;
    end

    // ========================================================
    // One store; the gap comes first, so back-to-back calls are legal
    task automatic store(input logic [31:0] a, input logic [31:0] d,
        input logic w);
    begin
        repeat (SPACING_CYC - 1) @(posedge clk_sys);
        wr_valid <= 1'b1;
        wr_addr <= a;
        wr_data <= d;
        wr_word <= w;
        @(posedge clk_sys);
        // Released lines show the inverse so no stale value passes
        wr_valid <= 1'b0;
        wr_addr <= ~a;
        wr_data <= ~d;
        wr_word <= ~w;
        #1; // Store settles before anything else is issued
    end
    endtask

    // ========================================================
    // Store issued too soon after the last one, to break the spacing
    task automatic store_fast(input logic [31:0] a, input logic [31:0] d);
    begin
        repeat (3) @(posedge clk_sys);
        wr_valid <= 1'b1;
        wr_addr <= a;
        wr_data <= d;
        wr_word <= 1'b1;
        @(posedge clk_sys);
        wr_valid <= 1'b0;
        wr_addr <= ~a;
        wr_data <= ~d;
        wr_word <= 1'b0;
        #1;
    end
    endtask

    // ========================================================
    // Stray flash read, only where a test asks for one
    task automatic stray_read;
    begin
        @(posedge clk_sys);
        rd_flash <= 1'b1;
        @(posedge clk_sys);
        rd_flash <= 1'b0;
        #1;
    end
    endtask
endmodule

//--- verif/testbench.sv
// Self-checking testbench for the flash command sequencer
`timescale 1ns/1ps
module testbench
    import fcs_pkg::*;
;
    // ========================================================
    // Signals
    logic clk_sys, resetn, array_done, array_fail, clk_en;
    logic [3:0] block_protect;
    logic wr_valid, wr_word, rd_flash;
    logic [31:0] wr_addr, wr_data;
    logic ready_busy_flag, mode_fail, cmd_abort, all_protected;
    logic op_start, prog_wr;
    logic [2:0] seq_pos;
    logic [1:0] op_kind;
    logic [31:0] op_addr, prog_data;
    int errors = 0;
    int checks = 0;
    localparam logic [31:0] ADR_A = {11'h000, KEY_A, 8'h00};
    localparam logic [31:0] ADR_B = {11'h000, KEY_B, 8'h00};
    localparam logic [31:0] ADR_BLK2 = 32'h0004_0000;

    // ========================================================
    // Design and host model
    fcs_sequencer #(.NBLK(4), .REGION_BASE(11'h000)) dut_u (
        .clk_sys(clk_sys), .resetn(resetn), .clk_en(clk_en),
        .wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data),
        .wr_word(wr_word), .rd_flash(rd_flash),
        .array_done(array_done), .array_fail(array_fail),
        .block_protect(block_protect),
        .ready_busy_flag(ready_busy_flag), .mode_fail(mode_fail),
        .seq_pos(seq_pos), .cmd_abort(cmd_abort),
        .all_protected(all_protected), .op_start(op_start),
        .op_kind(op_kind), .op_addr(op_addr), .prog_wr(prog_wr),
        .prog_data(prog_data)
    );
    fcs_host_model host_u (
        .clk_sys(clk_sys), .wr_valid(wr_valid), .wr_addr(wr_addr),
        .wr_data(wr_data), .wr_word(wr_word), .rd_flash(rd_flash)
    );

    // ========================================================
    // 40 MHz clock
    initial
    begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    // ========================================================
    // Shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    begin
        checks++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    end
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
    begin
        host_u.store(a, d, 1'b1);
    end
    endtask

    task automatic unlock;
    begin
        wr(ADR_A, DATA_UNLOCK_A);
        wr(ADR_B, DATA_UNLOCK_B);
    end
    endtask

    task automatic erase_pre;
    begin
        unlock();
        wr(ADR_A, CMD_ERASE);
        unlock();
        chk(seq_pos, POS_5);
    end
    endtask

    // Array engine end pulse, judged one edge later
    task automatic op_end(input logic fail);
    begin
        @(posedge clk_sys);
        array_done <= ~fail;
        array_fail <= fail;
        @(posedge clk_sys);
        array_done <= 1'b0;
        array_fail <= 1'b0;
        #1;
    end
    endtask

    task automatic summarize;
    begin
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    end
    endtask

    // ========================================================
    // Scenarios
    task automatic t_reset;
    begin
        chk(ready_busy_flag, 1'b1);
        chk(mode_fail, 1'b0);
        chk(seq_pos, POS_IDLE);
        chk(op_addr, ADDR_RESET);
        $display("test reset done");
    end
    endtask

    // Single read mid-sequence, then the three-cycle read/reset
    task automatic t_read;
    begin
        unlock();
        chk(seq_pos, POS_2);
        wr(32'h0001_2344, CMD_READ);
        chk(seq_pos, POS_IDLE);
        chk(ready_busy_flag, 1'b1);
        unlock();
        wr(ADR_A, CMD_READ);
        chk(seq_pos, POS_IDLE);
        chk(op_start, 1'b0);
        // A store while the clock enable is low must be ignored
        unlock();
        @(posedge clk_sys);
        clk_en <= 1'b0;
        wr(ADR_A, CMD_READ);
        chk(seq_pos, POS_2);
        @(posedge clk_sys);
        clk_en <= 1'b1;
        wr(ADR_A, CMD_READ);
        chk(seq_pos, POS_IDLE);
        $display("test read done");
    end
    endtask

    // Wrong region, data, width, key, then a stray read
    task automatic t_bad;
        logic [31:0] ba[4];
        logic [31:0] bd[4];
        logic bw[4];
    begin
        ba = '{ADR_B | 32'h0020_0000, ADR_B, ADR_B, ADR_A};
        bd = '{DATA_UNLOCK_B, 32'h0000_0011, DATA_UNLOCK_B, DATA_UNLOCK_B};
        bw = '{1'b1, 1'b1, 1'b0, 1'b1};
        for (int i = 0; i < 4; i++)
        begin
            wr(ADR_A, DATA_UNLOCK_A);
            host_u.store(ba[i], bd[i], bw[i]);
            chk(cmd_abort, 1'b1);
            chk(seq_pos, POS_IDLE);
        end
        wr(ADR_A, DATA_UNLOCK_A);
        host_u.store_fast(ADR_B, DATA_UNLOCK_B);
        chk(cmd_abort, 1'b1);
        chk(seq_pos, POS_IDLE);
        wr(ADR_A, DATA_UNLOCK_A);
        host_u.stray_read();
        chk(cmd_abort, 1'b1);
        chk(seq_pos, POS_IDLE);
        $display("test bad done");
    end
    endtask

    task automatic t_block;
    begin
        chk(ready_busy_flag, 1'b1);
        erase_pre();
        wr(ADR_BLK2, CMD_BLOCK);
        chk(op_start, 1'b1);
        chk(op_kind, OP_BLOCK);
        chk(op_addr, ADR_BLK2);
        chk(ready_busy_flag, 1'b0);
        @(posedge clk_sys);
        #1;
        chk(op_start, 1'b0);
        wr(ADR_A, CMD_READ);
        host_u.stray_read();
        chk(ready_busy_flag, 1'b0);
        op_end(1'b0);
        chk(ready_busy_flag, 1'b1);
        $display("test block done");
    end
    endtask

    task automatic t_fail;
    begin
        erase_pre();
        wr(ADR_A, CMD_CHIP);
        chk(op_kind, OP_CHIP);
        op_end(1'b1);
        chk(mode_fail, 1'b1);
        wr(ADR_A, DATA_UNLOCK_A);
        wr(ADR_B, 32'h0000_0011);
        chk(ready_busy_flag, 1'b0);
        unlock();
        wr(ADR_A, CMD_READ);
        chk(ready_busy_flag, 1'b1);
        chk(mode_fail, 1'b0);
        $display("test fail done");
    end
    endtask

    task automatic t_prog;
    begin
        unlock();
        wr(ADR_A, CMD_PROG);
        wr(32'h0000_0604, 32'hffff_ffff);
        chk(op_start, 1'b0);
        unlock();
        wr(ADR_A, CMD_PROG);
        wr(32'h0000_0600, 32'h1234_5678);
        chk(op_start, 1'b1);
        chk(op_kind, OP_PROG);
        chk(op_addr, 32'h0000_0600);
        wr(32'h0000_0604, 32'hcafe_0001);
        chk(prog_wr, 1'b1);
        chk(prog_data, 32'hcafe_0001);
        op_end(1'b0);
        chk(ready_busy_flag, 1'b1);
        $display("test prog done");
    end
    endtask

    task automatic t_protect;
    begin
        block_protect <= 4'hf;
        repeat (2) @(posedge clk_sys);
        #1;
        chk(all_protected, 1'b1);
        erase_pre();
        wr(ADR_A, CMD_CHIP);
        chk(op_start, 1'b0);
        chk(seq_pos, POS_IDLE);
        block_protect <= 4'h4;
        erase_pre();
        chk(all_protected, 1'b0);
        wr(ADR_BLK2, CMD_BLOCK);
        chk(ready_busy_flag, 1'b1);
        block_protect <= 4'h0;
        $display("test protect done");
    end
    endtask

    task automatic t_hwreset;
    begin
        erase_pre();
        wr(ADR_A, CMD_CHIP);
        chk(ready_busy_flag, 1'b0);
        @(posedge clk_sys);
        resetn <= 1'b0;
        #1;
        chk(ready_busy_flag, 1'b1);
        chk(seq_pos, POS_IDLE);
        @(posedge clk_sys);
        resetn <= 1'b1;
        wr(32'h0000_0100, CMD_READ);
        chk(ready_busy_flag, 1'b1);
        $display("test hwreset done");
    end
    endtask

    // ========================================================
    // Main sequence: reset held for 16 clocks
    initial
    begin
        resetn = 1'b0;
        clk_en = 1'b1;
        array_done = 1'b0;
        array_fail = 1'b0;
        block_protect = 4'h0;
        repeat (16) @(posedge clk_sys);
        resetn <= 1'b1;
        @(posedge clk_sys);
        #1;
        t_reset();
        t_read();
        t_bad();
        t_block();
        t_fail();
        t_prog();
        t_protect();
        t_hwreset();
        summarize();
    end

    // Watchdog: about 66 spaced stores need near 1000 clocks
    initial
    begin
        repeat (5000) @(posedge clk_sys);
        errors++;
        summarize();
    end
endmodule
